/* File: shared/rnf_pkg.sv */
// constants, register map and field layout of the notch filter bank
package rnf_pkg;
   // ************
   // sizes
   // ************
   localparam int NUM_NOTCH = 5;
   localparam int FREQ_W = 16;
   localparam int SAMP_W = 16;
   localparam int CNT_W = 32;

   // ************
   // register byte offsets
   // ************
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_NOTCH_BASE = 8'h04;
   localparam logic [7:0] OFS_NOTCH_STEP = 8'h08;
   localparam logic [7:0] OFS_SHAPE_REL = 8'h04;
   localparam logic [7:0] OFS_ROBUST = 8'h2c;
   localparam logic [7:0] OFS_STATUS = 8'h30;

   // ************
   // field layout
   // ************
   localparam int MODE_W = 2;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 4;
   localparam int DEPTH_LSB = 4;
   localparam int WIDTH_LSB = 8;
   localparam int SHAPE_W = 12;
   localparam int ST_ACTIVE_LSB = 0;
   localparam int ST_SHAFT = 5;
   localparam int ST_BUSY = 6;
   localparam int ST_EXCITE = 7;

   // ************
   // codes and reset values
   // ************
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [1:0] MODE_MANUAL = 2'h2;
   localparam logic [3:0] SEL_ON = 4'h1;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic [3:0] RST_ROBUST = 4'h0;
   localparam logic [15:0] RST_FREQ = 16'h1194;
   localparam logic [11:0] RST_SHAPE = 12'h000;

   // ************
   // frequency limits in Hz
   // ************
   localparam logic [15:0] FREQ_MIN = 16'h000a;
   localparam logic [15:0] FREQ_MAX = 16'h1194;
   localparam logic [15:0] TUNE_LO = 16'h0064;
   localparam logic [15:0] TUNE_HI = 16'h08ca;

   // ************
   // timing
   // ************
   localparam longint CLK_HZ = 125000000;
   localparam longint DETECT_S = 10;
   localparam longint EXCITE_S = 2;
   localparam longint DETECT_CYC = DETECT_S * CLK_HZ;
   localparam longint EXCITE_CYC = EXCITE_S * CLK_HZ;

   typedef enum logic {TN_IDLE, TN_RUN} rnf_tune_e;
endpackage

/* File: hdl/rnf_timer.sv */
// tuning interval counter with clear and run control
`timescale 1ns/100ps
module rnf_timer (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic clear,
   input wire logic run,
   output logic [rnf_pkg::CNT_W-1:0] count
);
   logic [rnf_pkg::CNT_W-1:0] next_count;

   // ************
   // counter
   // ************
   // clear wins over run, saturates at top
   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (run && count != '1) begin
         next_count = count + 1'b1;
      end
   end

   // register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
      end else if (ce) begin
         count <= next_count;
      end
   end
endmodule // rnf_timer

/* File: hdl/rnf_stage.sv */
// one notch stage with bypass when disabled
`timescale 1ns/100ps
module rnf_stage (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic enable,
   input wire logic [3:0] depth,
   input wire logic signed [rnf_pkg::SAMP_W-1:0] din,
   output logic signed [rnf_pkg::SAMP_W-1:0] dout
);
   logic signed [rnf_pkg::SAMP_W-1:0] atten;
   logic signed [rnf_pkg::SAMP_W-1:0] next_atten;

   // ************
   // stand-in gain reduction
   // ************
   // deeper setting removes a larger share of the sample
   always_comb begin
      next_atten = din - (din >>> (4'hf - depth));
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         atten <= '0;
      end else if (ce) begin
         atten <= next_atten;
      end
   end

   // disabled stage is a plain wire
   assign dout = enable ? atten : din;
endmodule // rnf_stage

/* File: hdl/rnf_top.sv */
// notch filter bank: parameter registers, enables and adaptive tuning
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module rnf_top #(
   parameter longint DETECT_CYCLES = rnf_pkg::DETECT_CYC,
   parameter longint EXCITE_CYCLES = rnf_pkg::EXCITE_CYC
) (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic CE,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // resonance detector report
   input wire logic RES_VALID,
   input wire logic [15:0] RES_FREQ,
   input wire logic [11:0] RES_SHAPE,
   // tough drive frequency rewrite
   input wire logic TOUGH_WR,
   input wire logic TOUGH_SEL,
   input wire logic [15:0] TOUGH_FREQ,
   // torque path
   input wire logic signed [15:0] SAMPLE_IN,
   output logic signed [15:0] SAMPLE_OUT,
   // filter controls
   output logic [4:0] NOTCH_ACTIVE,
   output logic [79:0] NOTCH_FREQ,
   output logic [59:0] NOTCH_SHAPE,
   output logic SHAFT_FILTER_EN,
   output logic ROBUST_FILTER_EN,
   output logic EXCITE
);
   localparam int N = rnf_pkg::NUM_NOTCH;
   // last count of the listen window, so a run lasts DETECT_CYCLES
   localparam logic [rnf_pkg::CNT_W-1:0] DET_LAST =
      rnf_pkg::CNT_W'(DETECT_CYCLES - 1);
   // length of the excitation burst at the start of a run
   localparam logic [rnf_pkg::CNT_W-1:0] EXC_LEN =
      rnf_pkg::CNT_W'(EXCITE_CYCLES);

   // ************
   // state
   // ************
   logic [1:0] filter_tuning_mode_param;
   logic [1:0] next_mode;
   logic [3:0] robust_filter_enable_param;
   logic [3:0] next_robust;
   logic [15:0] freq_param [N];
   logic [15:0] next_freq [N];
   logic [11:0] shape_param [N];
   logic [11:0] next_shape [N];
   rnf_pkg::rnf_tune_e tune_state;
   rnf_pkg::rnf_tune_e next_tune_state;
   logic ack;
   logic next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [rnf_pkg::CNT_W-1:0] tcount;
   logic timer_clear;
   logic timer_run;
   logic bus_req;
   logic bus_wr;
   logic [4:0] active;
   logic shaft_en;
   logic in_band;
   logic detect_over;
   logic tune_done;
   logic tune_busy;
   logic signed [15:0] chain [N+1];

   // merge written bytes into an old value
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wdat, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // hold a frequency inside the legal range
   function automatic logic [15:0] clamp(input logic [15:0] f);
      logic [15:0] res;
      res = f;
      if (f < rnf_pkg::FREQ_MIN) begin
         res = rnf_pkg::FREQ_MIN;
      end else if (f > rnf_pkg::FREQ_MAX) begin
         res = rnf_pkg::FREQ_MAX;
      end
      return res;
   endfunction

   // ************
   // bus decode
   // ************
   // one request per ack, ack dropped the cycle after
   assign bus_req = WB_CYC_I && WB_STB_I && !ack;
   assign bus_wr = bus_req && WB_WE_I;

   // ************
   // filter enables
   // ************
   // notch one manual settings count only in manual mode
   assign active[0] = filter_tuning_mode_param
      == rnf_pkg::MODE_MANUAL;
   assign active[1] = shape_param[1][rnf_pkg::SEL_LSB +: rnf_pkg::SEL_W]
      == rnf_pkg::SEL_ON;
   assign active[2] = shape_param[2][rnf_pkg::SEL_LSB +: rnf_pkg::SEL_W]
      == rnf_pkg::SEL_ON;
   assign active[3] = shape_param[3][rnf_pkg::SEL_LSB +: rnf_pkg::SEL_W]
      == rnf_pkg::SEL_ON;
   // robust filter masks notch five
   assign active[4] = (shape_param[4][rnf_pkg::SEL_LSB +: rnf_pkg::SEL_W]
      == rnf_pkg::SEL_ON) && !ROBUST_FILTER_EN;
   // shaft filter on unless notch four is on
   assign shaft_en = !active[3];

   // ************
   // tuning conditions
   // ************
   assign in_band = RES_FREQ >= rnf_pkg::TUNE_LO
      && RES_FREQ <= rnf_pkg::TUNE_HI;
   // listen window closes on its last counted cycle
   assign detect_over = tcount >= DET_LAST;
   // busy flag shared by excitation, result and status
   assign tune_busy = tune_state == rnf_pkg::TN_RUN;
   // an in-band report or the end of the window ends a run
   assign tune_done = tune_busy
      && ((RES_VALID && in_band) || detect_over);

   // ************
   // tuning sequencer
   // ************
   // mode 1 starts a run, leaving mode 1 aborts it
   always_comb begin
      next_tune_state = tune_state;
      timer_clear = 1'b0;
      timer_run = 1'b0;
      unique case (tune_state)
         rnf_pkg::TN_IDLE: begin
            // idle keeps the time base cleared
            timer_clear = 1'b1;
            if (filter_tuning_mode_param == rnf_pkg::MODE_AUTO) begin
               next_tune_state = rnf_pkg::TN_RUN;
            end
         end
         rnf_pkg::TN_RUN: begin
            timer_run = 1'b1;
            if (tune_done
               || filter_tuning_mode_param != rnf_pkg::MODE_AUTO) begin
               next_tune_state = rnf_pkg::TN_IDLE;
            end
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tune_state <= rnf_pkg::TN_IDLE;
      end else if (CE) begin
         tune_state <= next_tune_state;
      end
   end

   // listen and excitation time base
   rnf_timer u_timer (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .ce(CE),
      .clear(timer_clear),
      .run(timer_run),
      .count(tcount)
   );

   // excitation only in the first seconds of a run
   assign EXCITE = tune_busy && tcount < EXC_LEN;

   // ************
   // mode and robust registers
   // ************
   // tuning result overrides a same-cycle bus write
   always_comb begin
      next_mode = filter_tuning_mode_param;
      next_robust = robust_filter_enable_param;
      if (bus_wr && WB_ADR_I == rnf_pkg::OFS_MODE && WB_SEL_I[0]) begin
         next_mode = WB_DAT_I[rnf_pkg::MODE_W-1:0];
      end
      if (bus_wr && WB_ADR_I == rnf_pkg::OFS_ROBUST && WB_SEL_I[0]) begin
         next_robust = WB_DAT_I[3:0];
      end
      if (tune_done && filter_tuning_mode_param == rnf_pkg::MODE_AUTO) begin
         next_mode = rnf_pkg::MODE_MANUAL;
      end
   end

   // mode and robust registers, reset to off
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         filter_tuning_mode_param <= rnf_pkg::RST_MODE;
         robust_filter_enable_param <= rnf_pkg::RST_ROBUST;
      end else if (CE) begin
         filter_tuning_mode_param <= next_mode;
         robust_filter_enable_param <= next_robust;
      end
   end

   assign ROBUST_FILTER_EN = robust_filter_enable_param
      == rnf_pkg::SEL_ON;

   // ************
   // per-notch parameters and stages
   // ************
   // each notch has its own frequency and shape word
   for (genvar i = 0; i < N; i++) begin : g_notch
      localparam logic [7:0] F_OFS = rnf_pkg::OFS_NOTCH_BASE
         + 8'(i) * rnf_pkg::OFS_NOTCH_STEP;
      localparam logic [7:0] S_OFS = F_OFS + rnf_pkg::OFS_SHAPE_REL;
      logic [31:0] fw;
      logic [31:0] sw;

      // bytes of a bus write merged into the old words
      assign fw = merge({16'h0000, freq_param[i]}, WB_DAT_I, WB_SEL_I);
      assign sw = merge({20'h00000, shape_param[i]}, WB_DAT_I, WB_SEL_I);

      // bus, tough drive and tuning writers
      always_comb begin
         next_freq[i] = freq_param[i];
         next_shape[i] = shape_param[i];
         if (bus_wr && WB_ADR_I == F_OFS) begin
            next_freq[i] = clamp(fw[15:0]);
         end
         if (bus_wr && WB_ADR_I == S_OFS) begin
            next_shape[i] = sw[11:0];
         end
         if (i < 2 && TOUGH_WR && TOUGH_SEL == 1'(i)) begin
            next_freq[i] = clamp(TOUGH_FREQ);
         end
         if (i == 0 && tune_done && RES_VALID && in_band) begin
            next_freq[i] = clamp(RES_FREQ);
            next_shape[i] = RES_SHAPE;
         end
      end

      // settings register, reset to the widest range
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            freq_param[i] <= rnf_pkg::RST_FREQ;
            shape_param[i] <= rnf_pkg::RST_SHAPE;
         end else if (CE) begin
            freq_param[i] <= next_freq[i];
            shape_param[i] <= next_shape[i];
         end
      end

      // flat copies for the filter datapath
      assign NOTCH_FREQ[i*16 +: 16] = freq_param[i];
      assign NOTCH_SHAPE[i*12 +: 12] = shape_param[i];

      // stage i in the torque chain
      rnf_stage u_stage (
         .clk(CORE_CLK),
         .arst_n(ARST_N),
         .ce(CE),
         .enable(active[i]),
         .depth(shape_param[i][rnf_pkg::DEPTH_LSB +: 4]),
         .din(chain[i]),
         .dout(chain[i+1])
      );
   end

   // ************
   // torque chain and flat outputs
   // ************
   // chain input is the raw sample, output the last stage
   assign chain[0] = SAMPLE_IN;
   assign SAMPLE_OUT = chain[N];
   assign NOTCH_ACTIVE = active;
   assign SHAFT_FILTER_EN = shaft_en;

   // ************
   // bus read and ack
   // ************
   // registered read data, zero for unmapped addresses
   always_comb begin
      next_ack = bus_req;
      next_rdata = rdata;
      if (bus_req && !WB_WE_I) begin
         next_rdata = 32'h00000000;
         if (WB_ADR_I == rnf_pkg::OFS_MODE) begin
            next_rdata[1:0] = filter_tuning_mode_param;
         end
         if (WB_ADR_I == rnf_pkg::OFS_ROBUST) begin
            next_rdata[3:0] = robust_filter_enable_param;
         end
         if (WB_ADR_I == rnf_pkg::OFS_STATUS) begin
            next_rdata[rnf_pkg::ST_ACTIVE_LSB +: 5] = active;
            next_rdata[rnf_pkg::ST_SHAFT] = shaft_en;
            next_rdata[rnf_pkg::ST_BUSY] = tune_busy;
            next_rdata[rnf_pkg::ST_EXCITE] = EXCITE;
         end
         // notch words repeat every eight bytes
         for (int k = 0; k < N; k++) begin
            if (WB_ADR_I == rnf_pkg::OFS_NOTCH_BASE
               + 8'(k) * rnf_pkg::OFS_NOTCH_STEP) begin
               next_rdata[15:0] = freq_param[k];
            end
            if (WB_ADR_I == rnf_pkg::OFS_NOTCH_BASE
               + 8'(k) * rnf_pkg::OFS_NOTCH_STEP
               + rnf_pkg::OFS_SHAPE_REL) begin
               next_rdata[11:0] = shape_param[k];
            end
         end
      end
   end

   // ack and read data registers
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack <= 1'b0;
         rdata <= 32'h00000000;
      end else if (CE) begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ************
   // bus outputs
   // ************
   // both come straight from flip-flops
   assign WB_ACK_O = ack;
   assign WB_DAT_O = rdata;
endmodule // rnf_top

/* File: verif/rnf_top_properties.sv */
// checker of the notch bank outputs against their causes
`timescale 1ns/100ps
module rnf_props #(
   parameter longint EXCITE_CYCLES = 50
) (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic TOUGH_WR,
   input wire logic signed [15:0] SAMPLE_IN,
   input wire logic signed [15:0] SAMPLE_OUT,
   input wire logic [4:0] NOTCH_ACTIVE,
   input wire logic [79:0] NOTCH_FREQ,
   input wire logic [59:0] NOTCH_SHAPE,
   input wire logic SHAFT_FILTER_EN,
   input wire logic ROBUST_FILTER_EN,
   input wire logic EXCITE
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   logic [31:0] exc_cnt;
   logic [31:0] next_exc_cnt;
   logic in_rng;
   // ************
   // helper logic
   // ************
   // length of the running excitation burst, and frequency range flag
   always_comb begin
      next_exc_cnt = EXCITE ? exc_cnt + 32'h1 : 32'h0;
      in_rng = 1'b1;
      for (int k = 0; k < 5; k++) begin
         if (NOTCH_FREQ[16*k +: 16] < 16'h000a) in_rng = 1'b0;
         if (NOTCH_FREQ[16*k +: 16] > 16'h1194) in_rng = 1'b0;
      end
   end
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) exc_cnt <= 32'h0;
      else if (CE) exc_cnt <= next_exc_cnt;
   end
   // ************
   // properties
   // ************
   sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O && CE; endsequence
   sequence s_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
   property p_ack; s_req |=> s_pulse; endproperty
   property p_shaft; SHAFT_FILTER_EN == !NOTCH_ACTIVE[3]; endproperty
   property p_robust; ROBUST_FILTER_EN |-> !NOTCH_ACTIVE[4]; endproperty
   property p_bypass; NOTCH_ACTIVE == 5'h00 |-> SAMPLE_OUT == SAMPLE_IN;
   endproperty
   property p_tough; TOUGH_WR && CE |=>
      $stable(NOTCH_SHAPE) && $stable(NOTCH_FREQ[79:32]); endproperty
   property p_range; in_rng; endproperty
   property p_exc_len; $fell(EXCITE) |-> exc_cnt == EXCITE_CYCLES
      || NOTCH_ACTIVE[0] || $past(WB_ACK_O); endproperty
   property p_exc_max; exc_cnt <= EXCITE_CYCLES; endproperty
   property p_exc_n1; EXCITE |-> !NOTCH_ACTIVE[0]; endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer is not one pulse");
   a_shaft: assert property (p_shaft)
      else $error("shaft enable disagrees with notch four");
   a_robust: assert property (p_robust)
      else $error("notch five active beside robust filter");
   a_bypass: assert property (p_bypass)
      else $error("idle bank does not pass sample");
   a_tough: assert property (p_tough)
      else $error("tough drive touched other settings");
   a_range: assert property (p_range)
      else $error("notch frequency out of range");
   a_exc_len: assert property (p_exc_len)
      else $error("excitation burst too short");
   a_exc_max: assert property (p_exc_max)
      else $error("excitation burst too long");
   a_exc_n1: assert property (p_exc_n1)
      else $error("notch one active while tuning");
endmodule // rnf_props
bind rnf_top rnf_props #(.EXCITE_CYCLES(EXCITE_CYCLES)) rnf_props_inst (
   .CORE_CLK, .ARST_N, .CE, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .TOUGH_WR,
   .SAMPLE_IN, .SAMPLE_OUT, .NOTCH_ACTIVE, .NOTCH_FREQ, .NOTCH_SHAPE,
   .SHAFT_FILTER_EN, .ROBUST_FILTER_EN, .EXCITE);

/* File: verif/rnf_top_bench.sv */
// self-checking bench of the notch filter bank
`timescale 1ns/100ps
module rnf_top_bench;
   localparam longint DET = 200;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rv = 1'b0;
   logic tw = 1'b0, ts = 1'b0, shaft, robust, exc;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, dato, r, rnd;
   logic [15:0] rf = 16'h0, tf = 16'h0;
   logic [11:0] rs = 12'h0;
   logic signed [15:0] sin = 16'sh0, sout;
   logic [4:0] act;
   logic [79:0] nf;
   logic [59:0] ns;
   logic [15:0] tv [3] = '{16'h0063, 16'h08cb, 16'h08ca};
   int error_cnt = 0, checks_done = 0, seed = 32'h2a67, n, a;
   int m_mode = 0, m_rob = 0, m_f [5] = '{5{4500}}, m_s [5] = '{5{0}};
   rnf_top #(.DETECT_CYCLES(DET), .EXCITE_CYCLES(50)) rnf_top_inst (
      .CORE_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
      .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .RES_VALID(rv),
      .RES_FREQ(rf), .RES_SHAPE(rs), .TOUGH_WR(tw), .TOUGH_SEL(ts),
      .TOUGH_FREQ(tf), .SAMPLE_IN(sin), .SAMPLE_OUT(sout),
      .NOTCH_ACTIVE(act), .NOTCH_FREQ(nf), .NOTCH_SHAPE(ns),
      .SHAFT_FILTER_EN(shaft), .ROBUST_FILTER_EN(robust), .EXCITE(exc));
   // clock and random torque samples
   always #4 clk = ~clk;
   always @(posedge clk) sin <= $random(seed);
   task automatic wrap_up();
      if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (e !== g) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input int ad, input logic [31:0] d);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad[7:0];
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      r = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n == 20) begin
         error_cnt++;
         wrap_up();
      end
      @(posedge clk);
   endtask
   // ************
   // reference model
   // ************
   function automatic int eact();
      int v;
      v = (m_mode == 2);
      for (int k = 1; k < 5; k++) if ((m_s[k] & 15) == 1) v |= 1 << k;
      if (m_rob == 1) v &= 15;
      return v;
   endfunction
   function automatic int ereg(input int ad);
      if (ad == 0) return m_mode;
      if (ad == 8'h2c) return m_rob;
      if (ad == 8'h30) return eact() | ((~eact() >> 3 & 1) << 5);
      if (ad > 8'h2c || ad < 4) return 0;
      return (ad & 4) ? m_f[(ad - 4) / 8] : m_s[(ad - 8) / 8];
   endfunction
   task automatic wr(input int ad, input logic [31:0] d);
      wb(1'b1, ad, d);
      if (ad == 0) m_mode = d[1:0];
      else if (ad == 8'h2c) m_rob = d[3:0];
      else if (ad & 4) m_f[(ad - 4) / 8] = d[15:0] < 10 ? 10 :
                                          d[15:0] > 4500 ? 4500 : d[15:0];
      else m_s[(ad - 8) / 8] = d[11:0];
   endtask
   // compares the enable, frequency and shape outputs, the idle-bank sample and every register with the model
   task automatic chk_all();
      chk("active", eact(), {27'h0, act});
      chk("shaft", ~eact() >> 3 & 1, {31'h0, shaft});
      chk("robust", m_rob == 1, {31'h0, robust});
      if (eact() == 0) begin
         chk("sample", sin, sout);
      end
      for (int k = 0; k < 5; k++) begin
         chk("freq", m_f[k], {16'h0, nf[16*k +: 16]});
         chk("shape", m_s[k], {20'h0, ns[12*k +: 12]});
      end
      for (int ad = 0; ad < 8'h38; ad += 4) begin
         wb(1'b0, ad, 32'h0);
         chk("register", ereg(ad), r);
      end
   endtask
   // ************
   // main sequence
   // ************
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk_all();
      // random settings with select digits near the enable value
      repeat (30) begin
         a = 4 + 4 * ({$random(seed)} % 11);
         rnd = $random(seed);
         if (!(a & 4) || a == 8'h2c) begin
            rnd[3:0] = {$random(seed)} % 3;
         end
         wr(a, rnd);
         wr(0, {$random(seed)} % 2 * 2);
         chk_all();
      end
      // tough drive rewrites only the two frequencies, clamped
      tw <= 1'b1; ts <= 1'b0; tf <= 16'h0005;
      @(posedge clk);
      ts <= 1'b1; tf <= 16'hffff;
      @(posedge clk);
      tw <= 1'b0;
      @(posedge clk);
      m_f[0] = 10;
      m_f[1] = 4500;
      chk_all();
      // adaptive run: two out-of-band reports, then an edge value
      wr(0, 32'h1);
      n = 0;
      while (exc !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("excite", 1, {31'h0, exc});
      if (exc !== 1'b1) begin
         wrap_up();
      end
      foreach (tv[i]) begin
         rv <= 1'b1; rf <= tv[i]; rs <= 12'h3a5;
         @(posedge clk);
      end
      rv <= 1'b0;
      @(posedge clk);
      m_mode = 2;
      m_f[0] = 2250;
      m_s[0] = 12'h3a5;
      chk_all();
      // run without a report ends by itself after the detect time
      wr(0, 32'h1);
      n = 0;
      while (act[0] !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("detect", 1, n >= DET - 10 && n <= DET);
      if (act[0] !== 1'b1) begin
         wrap_up();
      end
      // the timed-out run leaves notch one as it was, in manual mode
      m_mode = 2;
      chk_all();
      // a run aborted by writing mode zero
      wr(0, 32'h1);
      wr(0, 32'h0);
      m_mode = 0;
      chk_all();
      wrap_up();
   end
endmodule // rnf_top_bench
